// ===== hdl/uam_pin_map.v
// Purpose: remap the 8-bit link data bus for low-power, six-wire and
//          three-wire serial modes, and decode resistor enables
// Assumes: all inputs synchronous to mclk; the register file clears the
//          select bits when modeExitPulse fires
// Notes:   line levels pass to the bus without clocking in low power
`timescale 1ns/10ps
`include "uam_pin_map_regs.vh"

module uam_pin_map (
    // clock and reset
    input  wire       mclk,
    input  wire       rstn,
    // mode control from the register file
    input  wire       lowPowerSelect,
    input  wire       sixWireSerialSelect,
    input  wire       threeWireSerialSelect,
    input  wire       keepClockInSerial,
    output wire       modeExitPulse,
    output wire [1:0] busMode,
    // link-side control
    input  wire       haltStrobe,
    output wire       dirOut,
    output wire       clockActive,
    // link data bus, split into input, output and enable
    input  wire [7:0] dataIn,
    output reg  [7:0] dataOut,
    output reg  [7:0] dataOe,
    // synchronous-mode engine
    input  wire [7:0] syncDataOut,
    input  wire [7:0] syncDataOe,
    input  wire       syncDir,
    // event and receiver inputs
    input  wire       eventFlag,
    input  wire [1:0] lineLevel,
    input  wire       plusLineLevel,
    input  wire       minusLineLevel,
    input  wire       diffReceiverOut,
    input  wire       singleEndedZeroRx,
    // serial transmit toward the line drivers
    output reg        serialTxEnable,
    output reg        serialSendDiff,
    output reg        serialSendZeroReq,
    // resistor decode fields
    input  wire [1:0] transceiverSpeedSel,
    input  wire       terminationSel,
    input  wire [1:0] operatingKindSel,
    input  wire       plusLinePulldownReq,
    input  wire       minusLinePulldownReq,
    // resistor enables
    output wire       plusPullupOn,
    output wire       plusPulldownOn,
    output wire       minusPulldownOn,
    output wire       fastTerminationOn
);

    // ===========================================================
    // mode state machine
    reg  [1:0] mode_reg;
    reg  [1:0] mode_next;
    reg        keepClk_reg;
    reg        keepClk_next;
    reg        exit_reg;
    reg        exit_next;
    wire       altMode;

    assign altMode = (mode_reg != `UAM_ST_SYNC);

    // entry only while halt is low, so a held halt cannot bounce the bus
    // straight back out; low power wins over the serial selects
    always @* begin
        mode_next    = mode_reg;
        keepClk_next = keepClk_reg;
        exit_next    = 1'b0;
        case (mode_reg)
            `UAM_ST_SYNC: begin
                if (!haltStrobe && lowPowerSelect) begin
                    mode_next = `UAM_ST_LOWPWR;
                end else if (!haltStrobe && sixWireSerialSelect) begin
                    mode_next    = `UAM_ST_SIXWIRE;
                    keepClk_next = keepClockInSerial;
                end else if (!haltStrobe && threeWireSerialSelect) begin
                    mode_next    = `UAM_ST_THREEWIRE;
                    keepClk_next = keepClockInSerial;
                end
            end
            `UAM_ST_LOWPWR: begin
                if (haltStrobe) begin
                    mode_next = `UAM_ST_SYNC;
                    exit_next = 1'b1;
                end
            end
            `UAM_ST_SIXWIRE: begin
                keepClk_next = keepClockInSerial;
                if (haltStrobe) begin
                    mode_next = `UAM_ST_SYNC;
                    exit_next = 1'b1;
                end
            end
            `UAM_ST_THREEWIRE: begin
                keepClk_next = keepClockInSerial;
                if (haltStrobe) begin
                    mode_next = `UAM_ST_SYNC;
                    exit_next = 1'b1;
                end
            end
            default: begin
                mode_next = `UAM_ST_SYNC;
            end
        endcase
    end

    // state registers
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mode_reg    <= `UAM_ST_SYNC;
            keepClk_reg <= `UAM_RST_KEEPCLK;
            exit_reg    <= 1'b0;
        end else begin
            mode_reg    <= mode_next;
            keepClk_reg <= keepClk_next;
            exit_reg    <= exit_next;
        end
    end

    assign busMode       = mode_reg;
    assign modeExitPulse = exit_reg;

    // ===========================================================
    // direction and clock control
    // direction stays owned by the device for the whole alternate mode
    assign dirOut = altMode ? 1'b1 : syncDir;

    // clock stops in low power; serial modes keep it only on request
    assign clockActive = (mode_reg == `UAM_ST_SYNC) |
                         (((mode_reg == `UAM_ST_SIXWIRE) |
                           (mode_reg == `UAM_ST_THREEWIRE)) &
                          keepClk_reg);

    // ===========================================================
    // data bus remap
    // this is combinational by design: low-power line levels must reach
    // the pins without waiting for a clock that may be stopped
    always @* begin
        dataOut = 8'h00;
        dataOe  = 8'h00;
        case (mode_reg)
            `UAM_ST_SYNC: begin
                dataOut = syncDataOut;
                dataOe  = syncDataOe;
            end
            `UAM_ST_LOWPWR: begin
                dataOe                = 8'hff;
                dataOut[1:0]          = lineLevel;
                dataOut[`UAM_BIT_EVENT] = eventFlag;
            end
            `UAM_ST_SIXWIRE: begin
                // bits 2..0 belong to the link
                dataOe                  = 8'hf8;
                dataOut[`UAM_BIT_EVENT] = eventFlag;
                dataOut[`UAM_BIT_PLUS]  = plusLineLevel;
                dataOut[`UAM_BIT_MINUS] = minusLineLevel;
                dataOut[`UAM_BIT_RCV]   = diffReceiverOut;
            end
            `UAM_ST_THREEWIRE: begin
                dataOe = 8'hf8;
                dataOut[`UAM_BIT_EVENT] = eventFlag;
                // bits 1 and 2 turn around with the link's transmit enable
                if (!dataIn[`UAM_BIT_TXEN]) begin
                    dataOe[`UAM_BIT_DIFF]    = 1'b1;
                    dataOe[`UAM_BIT_SEZERO]  = 1'b1;
                    dataOut[`UAM_BIT_DIFF]   = diffReceiverOut;
                    dataOut[`UAM_BIT_SEZERO] = singleEndedZeroRx;
                end
            end
            default: begin
                dataOut = 8'h00;
                dataOe  = 8'h00;
            end
        endcase
    end

    // ===========================================================
    // serial transmit toward the line drivers
    // three-wire send data is only valid while the link owns the pins;
    // gating avoids forwarding our own received data back to the line
    always @* begin
        serialTxEnable    = 1'b0;
        serialSendDiff    = 1'b0;
        serialSendZeroReq = 1'b0;
        case (mode_reg)
            `UAM_ST_SIXWIRE: begin
                serialTxEnable    = dataIn[`UAM_BIT_TXEN];
                serialSendDiff    = dataIn[`UAM_BIT_DIFF];
                serialSendZeroReq = dataIn[`UAM_BIT_SEZERO];
            end
            `UAM_ST_THREEWIRE: begin
                serialTxEnable    = dataIn[`UAM_BIT_TXEN];
                serialSendDiff    = dataIn[`UAM_BIT_TXEN] &
                                    dataIn[`UAM_BIT_DIFF];
                serialSendZeroReq = dataIn[`UAM_BIT_TXEN] &
                                    dataIn[`UAM_BIT_SEZERO];
            end
            default: begin
                serialTxEnable    = 1'b0;
                serialSendDiff    = 1'b0;
                serialSendZeroReq = 1'b0;
            end
        endcase
    end

    // ===========================================================
    // resistor enables; link owns consistency of the fields
    uam_term_decode termDecode (
        .mclk                 (mclk),
        .rstn                 (rstn),
        .transceiverSpeedSel  (transceiverSpeedSel),
        .terminationSel       (terminationSel),
        .operatingKindSel     (operatingKindSel),
        .plusLinePulldownReq  (plusLinePulldownReq),
        .minusLinePulldownReq (minusLinePulldownReq),
        .plusPullupOn         (plusPullupOn),
        .plusPulldownOn       (plusPulldownOn),
        .minusPulldownOn      (minusPulldownOn),
        .fastTerminationOn    (fastTerminationOn)
    );

endmodule

// ===== hdl/uam_pin_map_regs.vh
// Purpose: constants for the alternate-mode pin map and resistor decode
// Assumes: included by its bare name from the design files under hdl/
// Notes:   definitions only
//
// Overview of operation
// - low power: bit 3 carries event flag
// - low power: bits 2, 7..4 driven low
// - halt strobe returns six-wire to synchronous
// - six-wire: event, plus, minus, receiver, low
// - keep-clock bit keeps clock in serial
// - halt strobe returns three-wire to synchronous
// - three-wire bit 1 turns with enable
// - three-wire bit 2 turns with enable
// - three-wire: event on 3, 7..4 low
// - decode fields; three-state kind disables all
// - pull-up only peripheral states with termination
// - pull-downs follow their request bits
// - fast termination: speed 00, termination 0
// - host suspend: pull-downs on, others off
// - host resume: pull-downs on, others off
// - direction held high in alternate modes
// - held halt strobe wakes to synchronous
// - low power bits 0, 1 combinational levels
`ifndef UAM_PIN_MAP_REGS_VH
`define UAM_PIN_MAP_REGS_VH

// ===========================================================
// bus mode states
`define UAM_ST_SYNC        2'h0
`define UAM_ST_LOWPWR      2'h1
`define UAM_ST_SIXWIRE     2'h2
`define UAM_ST_THREEWIRE   2'h3

// ===========================================================
// decode field encodings
`define UAM_OPKIND_TRISTATE 2'h1
`define UAM_SPEED_FAST      2'h0

// ===========================================================
// data bus bit positions
`define UAM_BIT_TXEN       0
`define UAM_BIT_DIFF       1
`define UAM_BIT_SEZERO     2
`define UAM_BIT_EVENT      3
`define UAM_BIT_PLUS       4
`define UAM_BIT_MINUS      5
`define UAM_BIT_RCV        6

// ===========================================================
// reset values
`define UAM_RST_ENABLES    1'h0
`define UAM_RST_KEEPCLK    1'h0

`endif

// ===== hdl/uam_term_decode.v
// Purpose: decode speed, termination, kind and pull-down fields into
//          resistor enables
// Assumes: fields are register outputs steady in mclk domain
// Notes:   enables are registered so they change one edge after a write
`timescale 1ns/10ps
`include "uam_pin_map_regs.vh"

module uam_term_decode (
    // clock and reset
    input  wire       mclk,
    input  wire       rstn,
    // decoding fields
    input  wire [1:0] transceiverSpeedSel,
    input  wire       terminationSel,
    input  wire [1:0] operatingKindSel,
    input  wire       plusLinePulldownReq,
    input  wire       minusLinePulldownReq,
    // resistor enables
    output reg        plusPullupOn,
    output reg        plusPulldownOn,
    output reg        minusPulldownOn,
    output reg        fastTerminationOn
);

    // ===========================================================
    // combinational decode
    reg  plusPullupNext;
    reg  plusPulldownNext;
    reg  minusPulldownNext;
    reg  fastTermNext;
    wire driversOff;

    assign driversOff = (operatingKindSel == `UAM_OPKIND_TRISTATE);

    // host states request the plus pull-down, so the pull-up tracks its
    // absence; suspend and resume with termination select then stay off
    always @* begin
        plusPullupNext    = terminationSel & ~plusLinePulldownReq;
        plusPulldownNext  = plusLinePulldownReq;
        minusPulldownNext = minusLinePulldownReq;
        fastTermNext      = (transceiverSpeedSel == `UAM_SPEED_FAST)
                            & ~terminationSel;
        if (driversOff) begin
            plusPullupNext    = 1'b0;
            plusPulldownNext  = 1'b0;
            minusPulldownNext = 1'b0;
            fastTermNext      = 1'b0;
        end
    end

    // ===========================================================
    // enables take the new fields on the following edge
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            plusPullupOn      <= `UAM_RST_ENABLES;
            plusPulldownOn    <= `UAM_RST_ENABLES;
            minusPulldownOn   <= `UAM_RST_ENABLES;
            fastTerminationOn <= `UAM_RST_ENABLES;
        end else begin
            plusPullupOn      <= plusPullupNext;
            plusPulldownOn    <= plusPulldownNext;
            minusPulldownOn   <= minusPulldownNext;
            fastTerminationOn <= fastTermNext;
        end
    end

endmodule

// ===== tb/test_uam_pin_map.sv
// Purpose: self-checking bench for the alternate-mode pin map
// Assumes: link model resolves the data bus
// Notes:   notes queue holds mask and expected snapshot
`timescale 1ns/10ps
module test_uam_pin_map;
    // ==========================================================
    // stimulus
    logic        mclk = 1'b0, rstn = 1'b0, haltStrobe = 1'b0;
    logic        keepClockInSerial = 1'b0, syncDir = 1'b0, eventFlag = 1'b0;
    logic        plusLineLevel = 1'b0, minusLineLevel = 1'b0;
    logic        diffReceiverOut = 1'b0, singleEndedZeroRx = 1'b0;
    logic  [1:0] lineLevel = 2'h0, linkMode = 2'h0, tbMode = 2'h0;
    logic  [2:0] linkTx = 3'h0, sel = 3'h0;
    logic  [6:0] fld = 7'h0;
    logic  [7:0] syncDataOut = 8'h0, syncDataOe = 8'h0;
    logic [31:0] r;
    logic        expPulse = 1'b0;
    logic [55:0] notes [$];
    logic  [6:0] rows [4] = '{7'h33, 7'h3b, 7'h17, 7'h18};
    int          fails = 0, n_tests = 0, seed = 96153;
    wire lowPowerSelect, sixWireSerialSelect, threeWireSerialSelect;
    wire [1:0] transceiverSpeedSel, operatingKindSel, busMode;
    wire terminationSel, plusLinePulldownReq, minusLinePulldownReq;
    wire modeExitPulse, dirOut, clockActive, serialTxEnable;
    wire serialSendDiff, serialSendZeroReq, plusPullupOn, plusPulldownOn;
    wire minusPulldownOn, fastTerminationOn;
    wire [7:0] dataIn, dataOut, dataOe;
    assign {lowPowerSelect, sixWireSerialSelect, threeWireSerialSelect} = sel;
    assign {transceiverSpeedSel, terminationSel, operatingKindSel,
            plusLinePulldownReq, minusLinePulldownReq} = fld;
    wire [27:0] seen = {dataOe, dataOut & dataOe, serialSendZeroReq,
        serialSendDiff, serialTxEnable, busMode, dirOut, clockActive,
        modeExitPulse, plusPullupOn, plusPulldownOn, minusPulldownOn,
        fastTerminationOn};
    uam_pin_map i_dut (.*);
    uam_link_model i_link (.mclk(mclk), .linkMode(linkMode), .linkTx(linkTx),
        .dataOut(dataOut), .dataOe(dataOe), .busLevel(dataIn));
    always #4 mclk = ~mclk;
    // ==========================================================
    // reference snapshot from the current inputs
    function automatic logic [27:0] model();
        logic [7:0] oe, out;
        logic [2:0] tx;
        logic       k, t;
        k = operatingKindSel != 2'h1;
        t = dataIn[0];
        oe = syncDataOe;
        out = syncDataOut;
        tx = 3'h0;
        if (tbMode == 2'h1) begin
            oe = 8'hff;
            out = {4'h0, eventFlag, 1'b0, lineLevel};
        end
        if (tbMode == 2'h2) begin
            oe = 8'hf8;
            out = {1'b0, diffReceiverOut, minusLineLevel, plusLineLevel,
                   eventFlag, 3'h0};
            tx = dataIn[2:0];
        end
        if (tbMode == 2'h3) begin
            oe = {5'h1f, ~t, ~t, 1'b0};
            out = {4'h0, eventFlag, singleEndedZeroRx, diffReceiverOut, 1'b0};
            tx = {t & dataIn[2], t & dataIn[1], t};
        end
        return {oe, out & oe, tx, tbMode, tbMode != 2'h0 || syncDir,
            tbMode == 2'h0 || (tbMode[1] && keepClockInSerial), expPulse,
            {4{rstn & k}} & {terminationSel & ~plusLinePulldownReq,
            plusLinePulldownReq, minusLinePulldownReq,
            transceiverSpeedSel == 2'h0 && !terminationSel}};
    endfunction
    task automatic check(input logic [27:0] got, input logic [27:0] exp,
                         input string what);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // tx bits are only defined in serial modes
    task automatic chk();
        @(negedge mclk);
        notes.push_back({16'hffff, {3{tbMode[1]}}, 9'h1ff, model()});
    endtask
    task automatic cyc();
        @(posedge mclk);
        r = $random(seed);
        {eventFlag, lineLevel, plusLineLevel, minusLineLevel, syncDir,
         diffReceiverOut, singleEndedZeroRx, linkTx} <= r[10:0];
        {syncDataOut, syncDataOe} <= r[26:11];
    endtask
    // compare oldest note against what the outputs show
    always @(negedge mclk) begin
        logic [55:0] n;
        #1;
        while (notes.size() > 0) begin
            n = notes.pop_front();
            check(seen[27:9] & n[55:37], n[27:9], "bus");
            check(seen[8:4], n[8:4], "mode");
            check(seen[3:0], n[3:0], "enables");
        end
    end
    // enter a mode, try every select while in it, leave by halt
    task automatic runMode(input logic [1:0] m, input logic k);
        cyc();
        sel <= 3'h1 << (3 - m);
        keepClockInSerial <= k;
        cyc();
        tbMode = m;
        linkMode <= m;
        sel <= 3'h7;
        repeat (6) begin
            chk();
            cyc();
        end
        haltStrobe <= 1'b1;
        sel <= 3'h0;
        cyc();
        haltStrobe <= 1'b0;
        linkMode <= 2'h0;
        tbMode = 2'h0;
        expPulse = 1'b1;
        chk();
        cyc();
        expPulse = 1'b0;
        chk();
        $display("mode %0d keep %0d done", m, k);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ==========================================================
    // main sequence
    initial begin
        cyc();
        chk();
        cyc();
        cyc();
        rstn <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            cyc();
            fld <= (i < 4) ? rows[i] : r[31:25];
            cyc();
            chk();
        end
        $display("resistor decode done");
        cyc();
        haltStrobe <= 1'b1;
        sel <= 3'h7;
        repeat (3) begin
            cyc();
            chk();
        end
        cyc();
        haltStrobe <= 1'b0;
        sel <= 3'h0;
        $display("refusal under halt done");
        for (int k = 0; k < 2; k++)
            for (int m = 1; m < 4; m++)
                runMode(m[1:0], k[0]);
        @(posedge mclk);
        conclude();
    end
    // hang guard, far beyond the roughly 150 cycles needed
    initial begin
        repeat (3000) @(posedge mclk);
        fails++;
        conclude();
    end
endmodule

// ===== tb/uam_link_model.sv
// Purpose: link controller side of the data bus
// Assumes: linkMode tells which serial mode the link has written
// Notes:   undriven bits flip every cycle so stale values never match
`timescale 1ns/10ps
module uam_link_model (
    // clock
    input  wire logic       mclk,
    // link intent
    input  wire logic [1:0] linkMode,
    input  wire logic [2:0] linkTx,
    // device drive
    input  wire logic [7:0] dataOut,
    input  wire logic [7:0] dataOe,
    output wire logic [7:0] busLevel
);
    logic [7:0] drift = 8'h5a;
    wire        two = linkMode == 2'h2 || (linkMode == 2'h3 && linkTx[0]);
    wire  [7:0] own = {5'h0, two, two, linkMode[1]};
    // floating bits wander
    always @(posedge mclk) drift <= ~drift;
    // ==========================================================
    // wire resolution
    assign busLevel = (dataOe & dataOut) | (~dataOe & own & {5'h0, linkTx})
                    | (~dataOe & ~own & drift);
endmodule

// ===== tb/uam_pin_map_asserts.sv
// Purpose: concurrent checks on the alternate-mode pin map
// Assumes: bound to uam_pin_map; one clock domain
// Notes:   ports share lines to keep the checker short
`timescale 1ns/10ps
module uam_pin_map_asserts (
    // clock and reset
    input wire logic       mclk, rstn,
    // mode control
    input wire logic [1:0] busMode,
    input wire logic       keepClockInSerial, modeExitPulse, haltStrobe,
    input wire logic       dirOut, clockActive, eventFlag,
    // bus and receiver
    input wire logic [7:0] dataIn, dataOut, dataOe,
    input wire logic [1:0] lineLevel,
    input wire logic       plusLineLevel, minusLineLevel, diffReceiverOut,
    input wire logic       singleEndedZeroRx, serialTxEnable,
    input wire logic       serialSendDiff, serialSendZeroReq,
    // decode fields and enables
    input wire logic [1:0] transceiverSpeedSel, operatingKindSel,
    input wire logic       terminationSel, plusLinePulldownReq,
    input wire logic       minusLinePulldownReq, plusPullupOn,
    input wire logic       plusPulldownOn, minusPulldownOn,
    input wire logic       fastTerminationOn
);
    // ==========================================================
    // helpers
    wire lp  = busMode == 2'h1;
    wire six = busMode == 2'h2;
    wire thr = busMode == 2'h3;
    wire kon = operatingKindSel != 2'h1;   // three-state kind kills all
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    // ==========================================================
    // bus remap
    chk_lp_event: assert property (
        lp |-> dataOe[3] && dataOut[3] == eventFlag)
        else $error("event flag wrong in low power");
    chk_lp_low: assert property (
        lp |-> dataOe == 8'hff && !dataOut[2] && dataOut[7:4] == 4'h0)
        else $error("low power reserved bits wrong");
    chk_lp_level: assert property (
        lp |-> dataOut[1:0] == lineLevel)
        else $error("line levels wrong in low power");
    chk_six_map: assert property (
        six |-> dataOe == 8'hf8 && dataOut[7:3] == {1'b0, diffReceiverOut,
            minusLineLevel, plusLineLevel, eventFlag} &&
            {serialSendZeroReq, serialSendDiff, serialTxEnable} == dataIn[2:0])
        else $error("six-wire map wrong");
    chk_three_turn: assert property (
        thr |-> dataOe[2:1] == {2{~dataIn[0]}} && (dataIn[0] ||
            dataOut[2:1] == {singleEndedZeroRx, diffReceiverOut}))
        else $error("three-wire turnaround wrong");
    chk_three_low: assert property (
        thr |-> dataOe[7:3] == 5'h1f && dataOut[7:3] == {4'h0, eventFlag})
        else $error("three-wire upper bits wrong");
    // ==========================================================
    // mode exit, direction and clock
    chk_halt_exit: assert property (
        busMode != 2'h0 && haltStrobe |=> busMode == 2'h0 && modeExitPulse)
        else $error("halt did not restore sync mode");
    chk_alt_dir: assert property (busMode != 2'h0 |-> dirOut)
        else $error("direction low in alternate mode");
    chk_clk_keep: assert property (
        busMode[1] && $stable(keepClockInSerial) |->
            clockActive == keepClockInSerial)
        else $error("clock keep wrong in serial mode");
    // ==========================================================
    // resistor enables, one edge behind their fields; attempts start only
    // once rstn is sampled high, since the releasing edge still resets
    chk_fast_term: assert property (
        rstn |=> fastTerminationOn ==
            $past(kon && transceiverSpeedSel == 2'h0 && !terminationSel))
        else $error("fast termination wrong");
    chk_pull_down: assert property (
        rstn |=> {plusPulldownOn, minusPulldownOn} == $past({2{kon}} &
            {plusLinePulldownReq, minusLinePulldownReq}))
        else $error("pull-down enables wrong");
    chk_pull_up: assert property (
        rstn |=> plusPullupOn ==
            $past(kon && terminationSel && !plusLinePulldownReq))
        else $error("pull-up enable wrong");
    chk_host_rows: assert property (
        rstn && transceiverSpeedSel == 2'h1 && terminationSel &&
        !operatingKindSel[0] && plusLinePulldownReq && minusLinePulldownReq
        |=> plusPulldownOn && minusPulldownOn && !plusPullupOn &&
            !fastTerminationOn)
        else $error("host suspend or resume enables wrong");
    chk_tristate_off: assert property (
        operatingKindSel == 2'h1 |=> !(plusPullupOn || plusPulldownOn ||
            minusPulldownOn || fastTerminationOn))
        else $error("enables on in three-state kind");
    cover property (thr && !dataIn[0]);
    cover property (six && keepClockInSerial);
    cover property (modeExitPulse);
endmodule
bind uam_pin_map uam_pin_map_asserts i_chk (.*);
